// >>> inc/gsc_map.vh
// register layout, field positions, codes and frame constants of the gyro serial port
`ifndef GSC_MAP_VH
`define GSC_MAP_VH

`define GSC_FRAME_BITS     5'h10
`define GSC_BIT_WRITE      15
`define GSC_BIT_ZERO_HI    14
`define GSC_BIT_SRC_HI     11
`define GSC_BIT_SRC_LO     10
`define GSC_BIT_ONE_HI     9
`define GSC_BIT_ONE_LO     8
`define GSC_BIT_ZERO_LO    5
`define GSC_BIT_CODING     4
`define GSC_SRC_RATE       2'h0
`define GSC_SRC_TEMP       2'h1
`define GSC_SRC_AUX_ONE    2'h2
`define GSC_SRC_AUX_TWO    2'h3
`define GSC_CODING_TWOS    1'h0
`define GSC_CODING_OFFSET  1'h1
`define GSC_CTRL_RESET     3'h0
`define GSC_OFFSET_BIN     12'h0800

`endif

// >>> rtl/gsc_shift_tx.v
// output shifter: loads the framed sample word and walks it out msb first
`timescale 1ns/1ps
module gsc_shift_tx (
    input  wire        ref_clk_i,   // system clock
    input  wire        resetn_i,    // async reset, active low
    input  wire        load_i,      // load word at frame start
    input  wire        shift_i,     // advance one bit
    input  wire [15:0] word_i,      // word to send
    output wire        bit_o        // current output bit
);
    reg [15:0] sh_q;

    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sh_q <= 16'h0000;
        end else if (load_i) begin
            sh_q <= word_i;
        end else if (shift_i) begin
            sh_q <= {sh_q[14:0], 1'b0};
        end
    end

    assign bit_o = sh_q[15];
endmodule // gsc_shift_tx

// >>> rtl/gsc_spi_port.v
// serial control word decoder and sample word formatter for the gyro readout port
// Notes on behaviour
// - input bit 15 high loads the control register; low means plain read, no change.
// - bits 11:10 pick source: rate, temperature, aux one, aux two.
// - bit 4 picks coding: 0 twos complement, 1 offset binary.
// - twos rate samples are 12-bit signed, 0.2439 deg/s per count.
// - offset-binary rate samples add 2048 to the signed value.
// - output word is 00, 2-bit source tag, then the 12-bit sample.
// - twos temperature samples signed, zero at 25 degC.
// - offset-binary temperature samples add 2048.
// - twos aux samples signed, 0.001221 V per count.
// - offset-binary aux samples add 2048.
// - only a full 16-clock frame updates control and conversion result.
// - input bits sampled on falling serial clock edge, msb first.
// - first zero after select falls, bits change on falling edges, release after 16th.
// - select high: output released, clock and data have no effect.
`timescale 1ns/1ps
`include "gsc_map.vh"
module gsc_spi_port (
    input  wire        ref_clk_i,       // 25 MHz system clock
    input  wire        resetn_i,        // async reset, active low
    input  wire        cs_n_i,          // chip select pin, active low
    input  wire        sclk_i,          // serial clock pin
    input  wire        din_i,           // serial data in pin
    input  wire [11:0] rate_sample_i,   // signed rate sample
    input  wire [11:0] temp_sample_i,   // signed temperature sample
    input  wire [11:0] aux_one_i,       // signed aux_input_one sample
    input  wire [11:0] aux_two_i,       // signed aux_input_two sample
    output reg         dout_o,          // serial data out
    output reg         dout_oe_o,       // high while dout is driven
    output reg  [1:0]  source_select_o, // {source_select_hi, source_select_lo}
    output reg         coding_o,        // 1 = offset binary
    output reg         frame_done_o     // pulse after a complete frame
);
    // select a sample and apply coding
    function [11:0] gsc_code;
        input [1:0]  src;
        input        offs;
        input [11:0] r;
        input [11:0] t;
        input [11:0] a1;
        input [11:0] a2;
        reg   [11:0] v;
        begin
            case (src)
                `GSC_SRC_RATE:    v = r;
                `GSC_SRC_TEMP:    v = t;
                `GSC_SRC_AUX_ONE: v = a1;
                default:          v = a2;
            endcase
            // adding 2048 mod 4096 just flips the sign bit
            gsc_code = offs ? (v ^ `GSC_OFFSET_BIN) : v;
        end
    endfunction

    // frame states, one-hot
    localparam [2:0] ST_IDLE  = 3'b001;  // deselected
    localparam [2:0] ST_SHIFT = 3'b010;  // selected, taking bits
    localparam [2:0] ST_HOLD  = 3'b100;  // 16 bits taken, wait for deselect

    // pin synchronisers, two flip-flops each
    reg  [1:0]  cs_s_q;
    reg  [1:0]  sclk_s_q;
    reg  [1:0]  din_s_q;
    // previous synchronised levels for edge finding
    reg         sclk_d1_q;
    reg         cs_d1_q;
    // frame tracking
    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [4:0]  cnt_q;
    reg  [4:0]  cnt_d;
    // incoming control bits and the word the next frame sends
    reg  [15:0] rx_q;
    reg  [15:0] result_q;

    wire        cs_act;
    wire        sclk_s;
    wire        din_s;
    wire        cs_fall;
    wire        sclk_fe;
    wire        take_bit;
    wire        last_fe;
    wire        wr_frame;
    wire [1:0]  new_src;
    wire        new_coding;
    wire [15:0] next_result;
    wire        tx_bit;

    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cs_s_q   <= 2'h3;
            sclk_s_q <= 2'h0;
            din_s_q  <= 2'h0;
        end else begin
            cs_s_q   <= {cs_s_q[0], cs_n_i};
            sclk_s_q <= {sclk_s_q[0], sclk_i};
            din_s_q  <= {din_s_q[0], din_i};
        end
    end

    // only the second stage feeds logic; the first may be metastable
    assign cs_act   = ~cs_s_q[1];
    assign sclk_s   = sclk_s_q[1];
    assign din_s    = din_s_q[1];
    // history regs start at the idle pin levels so reset makes no false edge
    assign cs_fall  = cs_act & cs_d1_q;
    assign sclk_fe  = cs_act & sclk_d1_q & ~sclk_s;
    // edges after the 16th are ignored until the next select
    assign take_bit = sclk_fe & (state_q == ST_SHIFT);
    assign last_fe  = take_bit & (cnt_q == `GSC_FRAME_BITS - 5'h01);

    // the last bit still sits in din_s when the 16th edge is taken,
    // so the received word is one place short in rx_q
    assign wr_frame    = rx_q[`GSC_BIT_WRITE - 1];
    assign new_src     = rx_q[`GSC_BIT_SRC_HI - 1 -: 2];
    assign new_coding  = rx_q[`GSC_BIT_CODING - 1];
    // tag and sample use the setting in force before this frame's update
    assign next_result = {2'b00, source_select_o,
                          gsc_code(source_select_o, coding_o, rate_sample_i,
                                   temp_sample_i, aux_one_i, aux_two_i)};

    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_d1_q <= 1'b0;
            cs_d1_q   <= 1'b1;
        end else begin
            sclk_d1_q <= sclk_s;
            cs_d1_q   <= ~cs_act;
        end
    end

    // a frame ends early when select rises before the 16th edge
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (cs_fall) begin
                    state_d = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (!cs_act) begin
                    state_d = ST_IDLE;
                end else if (last_fe) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!cs_act) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // the count restarts with every select, so a cut frame leaves no residue
    always @* begin
        cnt_d = cnt_q;
        if (!cs_act || cs_fall) begin
            cnt_d = 5'h00;
        end else if (take_bit) begin
            cnt_d = cnt_q + 5'h01;
        end
    end

    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            cnt_q   <= 5'h00;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_q <= 16'h0000;
        end else if (take_bit) begin
            rx_q <= {rx_q[14:0], din_s};
        end
    end

    // fixed bits 14, 9, 8 and 5 are the host's duty and go unchecked
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            source_select_o <= `GSC_SRC_RATE;
            coding_o        <= `GSC_CODING_TWOS;
        end else if (last_fe && wr_frame) begin
            source_select_o <= new_src;
            coding_o        <= new_coding;
        end
    end

    // conversion completes only on the 16th edge; the first frame after reset reads zero
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            result_q <= 16'h0000;
        end else if (last_fe) begin
            result_q <= next_result;
        end
    end

    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frame_done_o <= 1'b0;
            dout_oe_o    <= 1'b0;
            dout_o       <= 1'b0;
        end else begin
            frame_done_o <= last_fe;
            // the shifter holds the new word only from the next cycle,
            // so the leading zero is forced here rather than read from it
            if (!cs_act || cs_fall) begin
                dout_o <= 1'b0;
            end else begin
                dout_o <= tx_bit;
            end
            if (!cs_act || last_fe) begin
                dout_oe_o <= 1'b0;
            end else if (cs_fall) begin
                dout_oe_o <= 1'b1;
            end
        end
    end

    gsc_shift_tx u_tx (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .load_i    (cs_fall),
        .shift_i   (take_bit),
        .word_i    (result_q),
        .bit_o     (tx_bit)
    );
endmodule // gsc_spi_port

// >>> sim/gsc_spi_port_props.sv
// checker for the gyro serial port pins and control outputs
`timescale 1ns/1ps
module gsc_spi_port_chk (
    input wire       ref_clk_i,       // clock
    input wire       resetn_i,        // reset, active low
    input wire       cs_n_i,          // select
    input wire       dout_o,          // data out
    input wire       dout_oe_o,       // out enable
    input wire [1:0] source_select_o, // source
    input wire       coding_o,        // coding
    input wire       frame_done_o     // frame end
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_idle_off; cs_n_i [*6] |-> !dout_oe_o; endproperty
    a_idle_off: assert property (p_idle_off) else $error("driven while idle");
    property p_idle_done; cs_n_i [*6] |-> !frame_done_o; endproperty
    a_idle_done: assert property (p_idle_done) else $error("done while idle");
    property p_done_one; frame_done_o |=> !frame_done_o; endproperty
    a_done_one: assert property (p_done_one) else $error("done too long");
    property p_done_sel; frame_done_o |-> !$past(cs_n_i, 3); endproperty
    a_done_sel: assert property (p_done_sel) else $error("done unselected");
    property p_src_hold;
        source_select_o != $past(source_select_o) |-> frame_done_o || $past(frame_done_o);
    endproperty
    a_src_hold: assert property (p_src_hold) else $error("source moved");
    property p_cod_hold;
        coding_o != $past(coding_o) |-> frame_done_o || $past(frame_done_o);
    endproperty
    a_cod_hold: assert property (p_cod_hold) else $error("coding moved");
    property p_oe_rise; $rose(dout_oe_o) |-> !$past(cs_n_i, 2); endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("early drive");
    property p_first_zero; $rose(dout_oe_o) |-> !dout_o; endproperty
    a_first_zero: assert property (p_first_zero) else $error("first bit high");
    property p_oe_drop; frame_done_o |-> ##[0:3] !dout_oe_o; endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("not released");
endmodule // gsc_spi_port_chk
bind gsc_spi_port gsc_spi_port_chk u_chk (.ref_clk_i, .resetn_i, .cs_n_i, .dout_o,
    .dout_oe_o, .source_select_o, .coding_o, .frame_done_o);

// >>> sim/gsc_host_model.sv
// host model: mode 1 master that frames words and collects the reply
`timescale 1ns/1ps
module gsc_host_model (
    input  wire ref_clk_i, // pacing clock
    input  wire dout_i,    // reply line
    output reg  cs_n_o,    // select
    output reg  sclk_o,    // serial clock
    output reg  din_o      // command line
);
    initial cs_n_o = 1'b1;
    initial sclk_o = 1'b0;
    initial din_o = 1'b0;
    // n below 16 gives a short frame; sclk stands still between frames
    task frame(input [15:0] w, input integer n, output [15:0] r);
        integer i;
        begin
            r = 16'h0000;
            @(posedge ref_clk_i) cs_n_o <= 1'b0;
            repeat (8) @(posedge ref_clk_i);
            for (i = 0; i < n; i = i + 1) begin
                din_o <= w[15 - i];
                sclk_o <= 1'b1;
                repeat (4) @(posedge ref_clk_i);
                r = {r[14:0], dout_i};
                sclk_o <= 1'b0;
                repeat (4) @(posedge ref_clk_i);
            end
            repeat (4) @(posedge ref_clk_i);
            cs_n_o <= 1'b1;
            din_o <= ~din_o;
            repeat (8) @(posedge ref_clk_i);
        end
    endtask
endmodule // gsc_host_model

// >>> sim/gsc_spi_port_tb_top.sv
// bench top: config sweep over every source and coding, read and short frames through the host model
`timescale 1ns/1ps
module gsc_spi_port_tb_top;
    reg         ref_clk_i = 1'b0;
    reg         resetn_i  = 1'b0;
    reg  [11:0] smp [0:3];
    reg  [15:0] w, r;
    wire        cs_n, sclk, din, dout, oe, cod, done, dout_line;
    wire [1:0]  src;
    integer     num_errors = 0, compares = 0, i, k;
    always #20 ref_clk_i = ~ref_clk_i;
    // a released line shows the inverse, so a read outside the driven window fails
    assign dout_line = oe ? dout : ~dout;
    gsc_host_model host (.ref_clk_i(ref_clk_i), .dout_i(dout_line), .cs_n_o(cs_n),
        .sclk_o(sclk), .din_o(din));
    gsc_spi_port dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n),
        .sclk_i(sclk), .din_i(din), .rate_sample_i(smp[0]), .temp_sample_i(smp[1]),
        .aux_one_i(smp[2]), .aux_two_i(smp[3]), .dout_o(dout), .dout_oe_o(oe),
        .source_select_o(src), .coding_o(cod), .frame_done_o(done));
    function [15:0] expw(input [1:0] s, input c);
        expw = {2'b00, s, c ? smp[s] + 12'h800 : smp[s]};
    endfunction
    // end points per source and coding, kk = 2 * source + coding
    function [11:0] corner(input integer kk);
        case (kk)
            0, 1: corner = 12'h4ce;
            2: corner = 12'h19d;
            3: corner = 12'he41;
            4: corner = 12'h666;
            default: corner = 12'h99a;
        endcase
    endfunction
    task chk(input [79:0] nm, input [15:0] e, input [15:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("unexpected %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task results;
        begin
            $display("errors %0d compares %0d", num_errors, compares);
            if (num_errors == 0 && compares > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        #2000000;
        num_errors = num_errors + 1;
        results;
    end
    initial begin
        for (i = 0; i < 4; i = i + 1) smp[i] = 12'h000;
        i = $urandom(69953);
        repeat (3) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        #1 chk("ctrl_rst", 16'h0000, {13'h0000, src, cod});
        @(posedge ref_clk_i);
        for (k = 0; k < 8; k = k + 1) begin
            for (i = 0; i < 4; i = i + 1)
                smp[i] <= (k < 6 && i == k / 2) ? corner(k) : $urandom;
            w = 16'h8300 | {4'h0, k[2:1], 5'h00, k[0], 4'h0} | ($urandom & 16'h30cf);
            host.frame(w, 16, r);
            chk("ctrl", {13'h0000, k[2:1], k[0]}, {13'h0000, src, cod});
            host.frame($urandom & 16'h7fff, 16, r);
            chk("ctrl_rd", {13'h0000, k[2:1], k[0]}, {13'h0000, src, cod});
            host.frame(w ^ 16'h0c10, 10, r);
            chk("ctrl_short", {13'h0000, k[2:1], k[0]}, {13'h0000, src, cod});
            host.frame(16'h0300, 16, r);
            chk("word", expw(k[2:1], k[0]), r);
        end
        results;
    end
endmodule // gsc_spi_port_tb_top
